// [hw/pim_intc.sv]
// Prioritized interrupt mask and poll logic with an AXI4-Lite register slave
// Overview of operation
// - Write one in interrupt mode sets mask
// - Write zero in interrupt mode clears mask
// - Mode bit zero selects interrupt mode
// - Mask bits hold until rewritten
// - Requests active only while input low
// - Timer expiry with level-3 mask requests interrupt
// - Poll of bit 3 returns pin level (the code polls in interrupt mode only and answers SLVERR in timer mode)
// - Timer expiry disables level-3 until rewritten
// - Poll bits return present request pin levels (the code polls in interrupt mode only and answers SLVERR in timer mode)
// - Drive active-low request and 4-bit code
// - Lowest-numbered enabled active level wins
// - Mode bit one selects timer mode
// - Polling ignores the mask bits
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pim_params.svh"
module pim_intc #(
  parameter int LEVELS = `PIM_LEVELS
) (
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [`PIM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PIM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Request pins, bit i-1 is level i, active low
  input wire logic [LEVELS-1:0] requestPins_n,
  // Expiry pulse from the countdown timer
  input wire logic timerExpired,
  // Timer load value seen by the countdown datapath
  output logic [`PIM_TIMER_W-1:0] timerLoad,
  // Request strobe and level code to the processor
  output logic irq_to_cpu_n,
  output logic [3:0] level_code
);

  // Whole block state
  typedef struct packed {
    // Two flip-flop synchronizer for the request pins
    logic [LEVELS-1:0] pinMeta;
    logic [LEVELS-1:0] pinSync;
    // Mask bits, mode and timer arm
    logic [LEVELS:1] mask;
    pim_pkg::pim_mode_t mode;
    logic timerArmed;
    // Timer register shown to the countdown datapath
    logic [`PIM_TIMER_W-1:0] timerVal;
    // Held write address and data
    logic awHeld;
    logic [`PIM_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    // Write response
    logic bValid;
    logic [1:0] bResp;
    // Read response
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    // Registered request strobe and level code
    logic irqN;
    logic [3:0] code;
  } pim_state_t;

  // Registered state
  pim_state_t st_reg;
  // Next state
  pim_state_t st_next;
  // Levels that request now, level 3 includes the timer
  logic [LEVELS:1] activeLvl;
  // Held address and data execute this cycle
  logic doWrite;
  // Read address accepted this cycle
  logic doRead;
  // Mask bits of the held write data
  logic [LEVELS:1] wrMask;

  // Level 3 active from pin or armed timer expiry
  always_comb begin
    for (int i = 1; i <= LEVELS; i++) begin
      activeLvl[i] = ~st_reg.pinSync[i-1];
    end
    if (timerExpired && st_reg.timerArmed) begin
      activeLvl[`PIM_TIMER_LEVEL] = 1'b1;
    end
  end

  // Write runs once both halves are held and no response waits
  assign doWrite = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
  // Read runs when no read data waits
  assign doRead = s_axi_arvalid && !st_reg.rValid;
  // Bit i of the word is level i
  assign wrMask = st_reg.wData[LEVELS:1];

  // Next state
  always_comb begin
    st_next = st_reg;
    // Two-stage pin synchronizer
    st_next.pinMeta = requestPins_n;
    st_next.pinSync = st_reg.pinMeta;
    // Timer arm cleared on expiry; a rearm write in the same cycle sets it again below
    if (timerExpired) begin
      st_next.timerArmed = 1'b0;
    end
    // Write channel capture
    if (s_axi_awvalid && !st_reg.awHeld) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.wHeld) begin
      st_next.wHeld = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
    end
    // Write decode
    if (doWrite) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = `PIM_RESP_OKAY;
      if (st_reg.awAddr == `PIM_OFF_MODE) begin
        if (st_reg.wStrb[0]) begin
          st_next.mode = pim_pkg::pim_mode_t'(st_reg.wData[`PIM_MODE_BIT]);
        end
      end else if (st_reg.awAddr == `PIM_OFF_MASK) begin
        // Mask reachable only in interrupt mode
        if (st_reg.mode == pim_pkg::PIM_MODE_INT) begin
          if (st_reg.wStrb[0]) begin
            st_next.mask[7:1] = wrMask[7:1];
            if (wrMask[`PIM_TIMER_LEVEL]) begin
              st_next.timerArmed = 1'b1;
            end
          end
          if (st_reg.wStrb[1]) begin
            st_next.mask[LEVELS:8] = wrMask[LEVELS:8];
          end
        end else begin
          st_next.bResp = `PIM_RESP_SLVERR;
        end
      end else if (st_reg.awAddr == `PIM_OFF_TIMER) begin
        // Timer register reachable only in timer mode
        if (st_reg.mode == pim_pkg::PIM_MODE_TIMER && st_reg.wStrb[1:0] == 2'h3) begin
          st_next.timerVal = st_reg.wData[`PIM_TIMER_W:1];
        end else begin
          st_next.bResp = `PIM_RESP_SLVERR;
        end
      end else if (st_reg.awAddr == `PIM_OFF_POLL || st_reg.awAddr == `PIM_OFF_STATUS) begin
        st_next.bResp = `PIM_RESP_OKAY;
      end else begin
        st_next.bResp = `PIM_RESP_SLVERR;
      end
    end
    // Response leaves once the master takes it
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
    end
    // Read decode
    if (doRead) begin
      st_next.rValid = 1'b1;
      st_next.rData = 32'h0;
      st_next.rResp = `PIM_RESP_OKAY;
      if (s_axi_araddr == `PIM_OFF_MODE) begin
        st_next.rData[`PIM_MODE_BIT] = st_reg.mode;
      end else if (s_axi_araddr == `PIM_OFF_MASK) begin
        st_next.rData[LEVELS:1] = st_reg.mask;
      end else if (s_axi_araddr == `PIM_OFF_POLL) begin
        if (st_reg.mode == pim_pkg::PIM_MODE_INT) begin
          st_next.rData[LEVELS:1] = st_reg.pinSync;
        end else begin
          st_next.rResp = `PIM_RESP_SLVERR;
        end
      end else if (s_axi_araddr == `PIM_OFF_TIMER) begin
        st_next.rData[`PIM_TIMER_W:1] = st_reg.timerVal;
      end else if (s_axi_araddr == `PIM_OFF_STATUS) begin
        st_next.rData[0] = st_reg.timerArmed;
        st_next.rData[1] = ~st_reg.irqN;
        st_next.rData[5:2] = st_reg.code;
      end else begin
        st_next.rResp = `PIM_RESP_SLVERR;
      end
    end
    // Read data leaves once the master takes it
    if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
    end
    // Priority encoder, level 1 highest
    // Idle strobe high and code zero
    st_next.irqN = 1'b1;
    st_next.code = 4'h0;
    // Scan from the lowest priority so level 1 lands last
    for (int i = LEVELS; i >= 1; i--) begin
      if (activeLvl[i] && st_reg.mask[i]) begin
        st_next.irqN = 1'b0;
        st_next.code = 4'(i);
      end
    end
    // Synchronous reset
    if (!rst_n) begin
      st_next = '0;
      // Pin stages idle high so no false request follows reset
      st_next.pinMeta = '1;
      st_next.pinSync = '1;
      st_next.mask = `PIM_MASK_RST;
      st_next.timerVal = `PIM_TIMER_RST;
      st_next.mode = pim_pkg::PIM_MODE_INT;
      st_next.irqN = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // Outputs
  // Write channel handshake
  assign s_axi_awready = !st_reg.awHeld;
  assign s_axi_wready = !st_reg.wHeld;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = st_reg.bResp;
  // Read channel handshake
  assign s_axi_arready = !st_reg.rValid;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;
  // Timer and processor side
  assign timerLoad = st_reg.timerVal;
  assign irq_to_cpu_n = st_reg.irqN;
  assign level_code = st_reg.code;

  // Checks
  // Mask write with both mask bytes enabled in interrupt mode
  sequence maskWriteS;
    doWrite && st_reg.awAddr == `PIM_OFF_MASK && st_reg.mode == pim_pkg::PIM_MODE_INT && st_reg.wStrb[1:0] == 2'h3;
  endsequence

  // Expiry of an armed timer on an enabled level 3
  sequence timerFireS;
    timerExpired && st_reg.timerArmed && st_reg.mask[`PIM_TIMER_LEVEL];
  endsequence

  // Write that rearms the level-3 timer request
  logic rearmWrite;
  assign rearmWrite = doWrite && st_reg.awAddr == `PIM_OFF_MASK && st_reg.mode == pim_pkg::PIM_MODE_INT
    && st_reg.wStrb[0] && wrMask[`PIM_TIMER_LEVEL];

  // Mask takes the written bits
  mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    maskWriteS |=> st_reg.mask == $past(wrMask)) else $error("mask not written");
  // Mask holds without a write
  mask_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !doWrite |=> $stable(st_reg.mask)) else $error("mask changed without write");
  // Mask out of reach in timer mode
  mask_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && st_reg.mode == pim_pkg::PIM_MODE_TIMER |=> $stable(st_reg.mask)) else $error("mask written in timer mode");
  // No enabled active level, no request
  irq_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.mask & activeLvl) == '0 |=> irq_to_cpu_n) else $error("spurious request");
  // Level 1 beats every other level
  irq_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.mask[1] && activeLvl[1] |=> !irq_to_cpu_n && level_code == 4'h1) else $error("priority wrong");
  // Expiry disarms unless a rearm write lands with it
  timer_disarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    timerExpired && !rearmWrite |=> !st_reg.timerArmed) else $error("timer still armed");
  // Armed expiry raises level 3 when levels 1 and 2 are quiet
  timer_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    timerFireS ##0 ((st_reg.mask[2:1] & activeLvl[2:1]) == 2'h0) |=> !irq_to_cpu_n && level_code == 4'h3)
    else $error("timer request missing");
  // Mode bit follows its write
  mode_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && st_reg.awAddr == `PIM_OFF_MODE && st_reg.wStrb[0]
    |=> st_reg.mode == pim_pkg::pim_mode_t'($past(st_reg.wData[`PIM_MODE_BIT]))) else $error("mode not written");
  // Poll refused in timer mode
  poll_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    doRead && s_axi_araddr == `PIM_OFF_POLL && st_reg.mode == pim_pkg::PIM_MODE_TIMER
    |=> s_axi_rresp == `PIM_RESP_SLVERR) else $error("poll answered in timer mode");
  // Timer register takes its write in timer mode
  timer_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && st_reg.awAddr == `PIM_OFF_TIMER && st_reg.mode == pim_pkg::PIM_MODE_TIMER && st_reg.wStrb[1:0] == 2'h3
    |=> timerLoad == $past(st_reg.wData[`PIM_TIMER_W:1])) else $error("timer not written");
  // Idle strobe carries code zero
  idle_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq_to_cpu_n |-> level_code == 4'h0) else $error("code while idle");
  // Reset drops the request
  reset_irq_a: assert property (@(posedge clk)
    !rst_n |=> irq_to_cpu_n && level_code == 4'h0) else $error("request after reset");
  // Poll returns the synchronized pins
  poll_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    doRead && s_axi_araddr == `PIM_OFF_POLL && st_reg.mode == pim_pkg::PIM_MODE_INT
    |=> s_axi_rdata[LEVELS:1] == $past(st_reg.pinSync)) else $error("poll data wrong");
  // Reset clears every mask bit
  reset_mask_a: assert property (@(posedge clk)
    !rst_n |=> st_reg.mask == '0) else $error("mask not cleared by reset");
endmodule

// [hw/pim_params.svh]
// Register offsets, field positions, reset values and widths for the interrupt mask and poll block
`ifndef PIM_PARAMS_SVH
`define PIM_PARAMS_SVH
`define PIM_LEVELS 15
`define PIM_ADDR_W 5
`define PIM_OFF_MODE 5'h00
`define PIM_OFF_MASK 5'h04
`define PIM_OFF_POLL 5'h08
`define PIM_OFF_TIMER 5'h0c
`define PIM_OFF_STATUS 5'h10
`define PIM_MODE_BIT 0
`define PIM_TIMER_LEVEL 3
`define PIM_TIMER_W 14
`define PIM_MASK_RST 15'h0000
`define PIM_TIMER_RST 14'h0000
`define PIM_RESP_OKAY 2'h0
`define PIM_RESP_SLVERR 2'h2
`endif

// [hw/pim_pkg.sv]
// Types shared by the interrupt mask and poll block
package pim_pkg;
  // Operating mode selected by the mode control bit
  typedef enum logic [0:0] {
    PIM_MODE_INT = 1'b0,
    PIM_MODE_TIMER = 1'b1
  } pim_mode_t;
endpackage

// [testbench/pim_cpu_model.sv]
// Processor side model that turns a presented level into its trap vector addresses
`timescale 1ns/1ps
module pim_cpu_model (
  input wire logic clk,
  input wire logic irq_to_cpu_n,
  input wire logic [3:0] level_code,
  output logic [15:0] wpAddr,
  output logic [15:0] pcAddr
);
  // Vector fetch addresses, workspace word then program counter word
  always_ff @(posedge clk) begin
    if (!irq_to_cpu_n) begin
      wpAddr <= {10'h000, level_code, 2'h0};
      pcAddr <= {10'h000, level_code, 2'h2};
    end
  end
endmodule

// [testbench/test_prioritized_interrupt_mask_poll.sv]
// Self-checking bench for the interrupt mask and poll block
`timescale 1ns/1ps
`include "pim_params.svh"
module test_prioritized_interrupt_mask_poll;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, timerExpired;
  logic awready, wready, bvalid, arready, rvalid, irq_to_cpu_n;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, level_code;
  logic [1:0] bresp, rresp, rs;
  logic [14:0] pins;
  logic [13:0] timerLoad;
  logic [15:0] wpAddr, pcAddr;
  // Reference model state
  int mismatches, compares, maskM, armed, w, sawIrq;
  pim_intc i_pim_intc (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .requestPins_n(pins),
    .timerExpired(timerExpired), .timerLoad(timerLoad), .irq_to_cpu_n(irq_to_cpu_n),
    .level_code(level_code));
  pim_cpu_model i_pim_cpu_model (.clk(clk), .irq_to_cpu_n(irq_to_cpu_n), .level_code(level_code),
    .wpAddr(wpAddr), .pcAddr(pcAddr));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Verdict and end of run
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait ran out
  task automatic guard(input int n);
    if (n >= 100) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  // Register write, address and data offered together
  task automatic wrReg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic aT, wT, bT;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      aT = awvalid && awready === 1'b1;
      wT = wvalid && wready === 1'b1;
      bT = bvalid === 1'b1;
      if (bT) rs = bresp;
      @(posedge clk);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      n++;
    end while (!bT && n < 100);
    if (!bT) guard(n);
  endtask
  // Register read
  task automatic rdReg(input logic [4:0] a);
    int n;
    logic aT, rT;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      aT = arvalid && arready === 1'b1;
      rT = rvalid === 1'b1;
      if (rT) rd = rdata;
      if (rT) rs = rresp;
      @(posedge clk);
      if (aT) arvalid <= 1'b0;
      n++;
    end while (!rT && n < 100);
    if (!rT) guard(n);
  endtask
  // Winning level of the model, zero when idle
  function automatic int winner(input int m, input logic [14:0] p);
    for (int i = 1; i <= 15; i++) if (m[i] && p[i-1] === 1'b0) return i;
    return 0;
  endfunction
  // One expiry pulse, then watch the request output
  task automatic pulse();
    timerExpired <= 1'b1;
    @(posedge clk);
    timerExpired <= 1'b0;
    sawIrq = 0;
    repeat (5) begin
      @(negedge clk);
      if (irq_to_cpu_n === 1'b0 && level_code === 4'h3) sawIrq = 1;
      @(posedge clk);
    end
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h1cc38ba3));
    {rst_n, awvalid, wvalid, arvalid, timerExpired} = 5'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, wstrb} = '0;
    pins = 15'h7fff;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdReg(`PIM_OFF_MASK);
    chk(rd, 32'h0);
    // Random masks against random pins
    for (int k = 0; k < 12; k++) begin
      maskM = (k == 0) ? 32'hfffe : ($urandom & 32'hfffe);
      wrReg(`PIM_OFF_MASK, maskM, 4'h3);
      chk(rs, `PIM_RESP_OKAY);
      pins <= 15'($urandom | $urandom);
      repeat (4) @(posedge clk);
      w = winner(maskM, pins);
      chk({irq_to_cpu_n, level_code}, w == 0 ? 32'h10 : w);
      rdReg(`PIM_OFF_POLL);
      chk(rd & 32'hfffe, {pins, 1'b0});
      if (w != 0) chk({wpAddr, pcAddr}, {16'(4 * w), 16'(4 * w + 2)});
      rdReg(`PIM_OFF_MASK);
      chk(rd & 32'hfffe, maskM);
    end
    // Timer mode redirects the bit space
    pins <= 15'h7fff;
    wrReg(`PIM_OFF_MODE, 32'h1, 4'hf);
    wrReg(`PIM_OFF_MASK, 32'hfffe, 4'h3);
    chk(rs, `PIM_RESP_SLVERR);
    rdReg(`PIM_OFF_POLL);
    chk(rs, `PIM_RESP_SLVERR);
    w = $urandom & 32'h7ffe;
    wrReg(`PIM_OFF_TIMER, w, 4'hf);
    chk(timerLoad, w[14:1]);
    wrReg(`PIM_OFF_MODE, 32'h0, 4'hf);
    rdReg(`PIM_OFF_MASK);
    chk(rd & 32'hfffe, maskM);
    // Expiry, disarm, rearm by rewriting the level-3 mask
    wrReg(`PIM_OFF_MASK, 32'h8, 4'h3);
    chk(rs, `PIM_RESP_OKAY);
    armed = 1;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wrReg(`PIM_OFF_MASK, 32'h8, 4'h3);
      if (k == 2) armed = 1;
      pulse();
      chk(sawIrq, armed);
      armed = 0;
    end
    // Unmapped place
    wrReg(5'h14, 32'h0, 4'hf);
    chk(rs, `PIM_RESP_SLVERR);
    rdReg(5'h14);
    chk(rs, `PIM_RESP_SLVERR);
    // Second reset in mid-run clears the masks
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdReg(`PIM_OFF_MASK);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule
